// File: hw/tmi_pkg.sv
/*
 * Constants and types for the timer pin control and interrupt enable block.
 * Assumes a byte-wide register map reached over a plain strobe port.
 */
package tmi_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_IO_CTL = 4'h0;
    localparam logic [3:0] ADDR_IER0 = 4'h1;
    localparam logic [3:0] ADDR_IER1 = 4'h2;
    localparam logic [3:0] ADDR_IER2 = 4'h3;
    localparam logic [3:0] ADDR_STAT0 = 4'h4;
    localparam logic [3:0] ADDR_STAT1 = 4'h5;
    localparam logic [3:0] ADDR_STAT2 = 4'h6;
    localparam logic [3:0] ADDR_REGA2 = 4'h7;

    // ------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] IER_RESET = 8'h40;
    localparam logic [7:0] IO_CTL_RESET = 8'h00;
    localparam logic [7:0] IER_ONE_BITS = 8'h40;
    localparam logic [7:0] IER_WMASK_CH0 = 8'h1F;
    localparam logic [7:0] IER_WMASK_CH12 = 8'h33;
    localparam logic [5:0] FLAG_MASK_CH0 = 6'h1F;
    localparam logic [5:0] FLAG_MASK_CH12 = 6'h33;
    localparam logic [1:0] STAT_FIXED = 2'h3;
    localparam int IO_MODE_BIT = 3;
    localparam int IO_INIT_BIT = 2;
    localparam int FLAG_UF = 5;
    localparam int FLAG_OV = 4;
    localparam int FLAG_A = 0;
    localparam logic [1:0] OC_LOW = 2'h1;
    localparam logic [1:0] OC_HIGH = 2'h2;
    localparam logic [1:0] OC_TOGGLE = 2'h3;
    localparam int NUM_CH = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic underflow;
        logic overflow;
        logic regD;
        logic regC;
        logic regB;
        logic regA;
    } tmi_irq_t;

    typedef enum logic [2:0] {
        PIN_OFF = 3'b001,
        PIN_DRIVE = 3'b010,
        PIN_CAPTURE = 3'b100
    } tmi_pin_mode_t;

endpackage

// File: hw/tmi_timer_io_irq.sv
/*
 * Channel 2 pin A compare/capture control, per-channel interrupt enables,
 * status flags and interrupt request gating of a three-channel timer.
 * Assumes the counters, prescalers and other compare units live outside and
 * deliver counter values, count direction and one-cycle match strobes.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Compare match drives pin low in mode 01
// - Compare match drives pin high in mode 10
// - Compare match toggles pin in mode 11
// - Capture mode 00 latches counter on rising
// - Capture mode 01 latches counter on falling
// - Capture mode 1x latches on both edges
// - Enable registers eight bits, reset 0x40
// - Enable bit 7 reads zero; write zero
// - Enable bit 6 reads one; write zero
// - Channels 1,2 bit 5 gates underflow request
// - Channel 0 bit 5 reads zero, unwritable
// - Bit 4 gates overflow request everywhere
// - Channel 0 bit 3 gates register D request
// - Channel 0 bit 2 gates register C request
// - Channels 1,2 bits 3,2 read zero, unwritable
// - Bit 1 gates register B request everywhere
// - Bit 0 gates register A request everywhere
// - Overflow flag set on wrap to zero
// - Underflow flag set on wrap in phase mode
// - Flags cleared by zero after reading one
module tmi_timer_io_irq #(
    parameter int CNT_W = 16,
    parameter int DATA_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [DATA_W-1:0] regRdData,
    input wire logic [CNT_W-1:0] cntCh0,
    input wire logic [CNT_W-1:0] cntCh1,
    input wire logic [CNT_W-1:0] cntCh2,
    input wire logic [2:0] phaseMode,
    input wire logic [2:0] countUp,
    input wire logic [3:0] matchCh0,
    input wire logic [3:0] matchCh1,
    input wire logic [3:0] matchCh2,
    input wire logic chan2PinAIn,
    output logic chan2PinAOut,
    output logic chan2PinAOe,
    output tmi_pkg::tmi_irq_t irqCh0,
    output tmi_pkg::tmi_irq_t irqCh1,
    output tmi_pkg::tmi_irq_t irqCh2
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (CNT_W > DATA_W || DATA_W < 8)
    begin : gParamCheck
        $error("Counter must fit the data path, data at least a byte");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic wrapUp(input logic [CNT_W-1:0] prv,
                                    input logic [CNT_W-1:0] cur);
        wrapUp = (&prv) && (cur == '0);
    endfunction

    function automatic logic wrapDown(input logic [CNT_W-1:0] prv,
                                      input logic [CNT_W-1:0] cur);
        wrapDown = (prv == '0) && (&cur);
    endfunction

    function automatic logic [7:0] statByte(input logic [5:0] flg,
                                            input logic dirBit);
        statByte = {dirBit, 1'b1, flg};
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] ioCtl_ff;
    logic [7:0] ierCh_ff [tmi_pkg::NUM_CH];
    logic [5:0] flags_ff [tmi_pkg::NUM_CH];
    logic [5:0] armed_ff [tmi_pkg::NUM_CH];
    logic [CNT_W-1:0] prevCnt_ff [tmi_pkg::NUM_CH];
    logic [CNT_W-1:0] regA2_ff;
    logic [CNT_W-1:0] nxt_regA2;
    logic pinIn_ff;
    logic pinOut_ff;
    logic nxt_pinOut;
    logic [DATA_W-1:0] rdData_ff;
    logic [DATA_W-1:0] nxt_rdData;

    logic [CNT_W-1:0] cnt [tmi_pkg::NUM_CH];
    logic [3:0] match [tmi_pkg::NUM_CH];
    logic [5:0] flagMask [tmi_pkg::NUM_CH];
    logic [5:0] setEv [tmi_pkg::NUM_CH];
    logic [5:0] ierEn [tmi_pkg::NUM_CH];
    tmi_pkg::tmi_pin_mode_t pinMode;
    logic cmpMatch2;
    logic riseEv;
    logic fallEv;
    logic capEv;

    assign cnt[0] = cntCh0;
    assign cnt[1] = cntCh1;
    assign cnt[2] = cntCh2;
    assign match[0] = matchCh0;
    assign match[1] = matchCh1;
    assign match[2] = matchCh2;
    assign flagMask[0] = tmi_pkg::FLAG_MASK_CH0;
    assign flagMask[1] = tmi_pkg::FLAG_MASK_CH12;
    assign flagMask[2] = tmi_pkg::FLAG_MASK_CH12;

    // ------------------------------------------------------------
    // Channel 2 pin A mode decode
    // ------------------------------------------------------------
    always_comb
    begin
        if (ioCtl_ff[tmi_pkg::IO_MODE_BIT])
            pinMode = tmi_pkg::PIN_CAPTURE;
        else if (ioCtl_ff[1:0] != 2'h0)
            pinMode = tmi_pkg::PIN_DRIVE;
        else
            pinMode = tmi_pkg::PIN_OFF;
    end

    // Match only on the step into equality, so a stopped counter fires once
    assign cmpMatch2 = (cntCh2 == regA2_ff) && (cntCh2 != prevCnt_ff[2]);
    assign riseEv = chan2PinAIn && !pinIn_ff;
    assign fallEv = !chan2PinAIn && pinIn_ff;

    always_comb
    begin
        if (ioCtl_ff[1])
            capEv = riseEv || fallEv;
        else if (ioCtl_ff[0])
            capEv = fallEv;
        else
            capEv = riseEv;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pinIn_ff <= 1'b0;
        else
            pinIn_ff <= chan2PinAIn;
    end

    // ------------------------------------------------------------
    // Pin output level
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_pinOut = pinOut_ff;
        if (regWrEn && regAddr == tmi_pkg::ADDR_IO_CTL)
            nxt_pinOut = regWrData[tmi_pkg::IO_INIT_BIT];
        else if (pinMode == tmi_pkg::PIN_DRIVE && cmpMatch2)
        begin
            case (ioCtl_ff[1:0])
                tmi_pkg::OC_LOW: nxt_pinOut = 1'b0;
                tmi_pkg::OC_HIGH: nxt_pinOut = 1'b1;
                tmi_pkg::OC_TOGGLE: nxt_pinOut = !pinOut_ff;
                default: nxt_pinOut = pinOut_ff;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pinOut_ff <= 1'b0;
        else
            pinOut_ff <= nxt_pinOut;
    end

    assign chan2PinAOut = pinOut_ff;
    assign chan2PinAOe = (pinMode == tmi_pkg::PIN_DRIVE);

    // ------------------------------------------------------------
    // I/O control and general register A
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ioCtl_ff <= tmi_pkg::IO_CTL_RESET;
        else if (regWrEn && regAddr == tmi_pkg::ADDR_IO_CTL)
            ioCtl_ff <= regWrData[7:0];
    end

    always_comb
    begin
        nxt_regA2 = regA2_ff;
        if (pinMode == tmi_pkg::PIN_CAPTURE && capEv)
            nxt_regA2 = cntCh2;
        else if (regWrEn && regAddr == tmi_pkg::ADDR_REGA2)
            nxt_regA2 = regWrData[CNT_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            regA2_ff <= '1;
        else
            regA2_ff <= nxt_regA2;
    end

    // ------------------------------------------------------------
    // Enable registers, flags and requests per channel
    // ------------------------------------------------------------
    for (genvar ch = 0; ch < tmi_pkg::NUM_CH; ch++)
    begin : gCh
        logic [3:0] statAddr;
        logic [3:0] ierAddr;
        logic [7:0] wMask;
        logic [5:0] clrBits;
        logic regAEv;

        assign statAddr = tmi_pkg::ADDR_STAT0 + 4'(ch);
        assign ierAddr = tmi_pkg::ADDR_IER0 + 4'(ch);
        assign wMask = (ch == 0) ? tmi_pkg::IER_WMASK_CH0 : tmi_pkg::IER_WMASK_CH12;
        assign regAEv = (ch == 2) ?
            ((pinMode == tmi_pkg::PIN_CAPTURE) ? capEv : cmpMatch2) : match[ch][0];

        // Reserved bits never store, bit 6 is added on read
        always_ff @(posedge clk)
        begin
            if (!rst_n)
                ierCh_ff[ch] <= tmi_pkg::IER_RESET & wMask;
            else if (regWrEn && regAddr == ierAddr)
                ierCh_ff[ch] <= regWrData[7:0] & wMask;
        end

        always_ff @(posedge clk)
        begin
            if (!rst_n)
                prevCnt_ff[ch] <= '0;
            else
                prevCnt_ff[ch] <= cnt[ch];
        end

        always_comb
        begin
            setEv[ch] = {phaseMode[ch] && wrapDown(prevCnt_ff[ch], cnt[ch]),
                         wrapUp(prevCnt_ff[ch], cnt[ch]),
                         match[ch][3:1], regAEv} & flagMask[ch];
        end

        // Clear needs a prior read of one; a set in the same cycle wins
        assign clrBits = (regWrEn && regAddr == statAddr) ?
            (armed_ff[ch] & ~regWrData[5:0]) : 6'h00;

        always_ff @(posedge clk)
        begin
            if (!rst_n)
                flags_ff[ch] <= 6'h00;
            else
                flags_ff[ch] <= (flags_ff[ch] & ~clrBits) | setEv[ch];
        end

        always_ff @(posedge clk)
        begin
            if (!rst_n)
                armed_ff[ch] <= 6'h00;
            else if (regWrEn && regAddr == statAddr)
                armed_ff[ch] <= 6'h00;
            else if (regRdEn && regAddr == statAddr)
                armed_ff[ch] <= flags_ff[ch];
        end

        assign ierEn[ch] = ierCh_ff[ch][5:0];
    end

    // Bits 5..0 line up with the request struct
    assign irqCh0 = flags_ff[0] & ierEn[0];
    assign irqCh1 = flags_ff[1] & ierEn[1];
    assign irqCh2 = flags_ff[2] & ierEn[2];

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_rdData = '0;
        if (regRdEn)
        begin
            case (regAddr)
                tmi_pkg::ADDR_IO_CTL: nxt_rdData[7:0] = ioCtl_ff;
                tmi_pkg::ADDR_IER0: nxt_rdData[7:0] = ierCh_ff[0] | tmi_pkg::IER_ONE_BITS;
                tmi_pkg::ADDR_IER1: nxt_rdData[7:0] = ierCh_ff[1] | tmi_pkg::IER_ONE_BITS;
                tmi_pkg::ADDR_IER2: nxt_rdData[7:0] = ierCh_ff[2] | tmi_pkg::IER_ONE_BITS;
                tmi_pkg::ADDR_STAT0: nxt_rdData[7:0] = statByte(flags_ff[0], 1'b1);
                tmi_pkg::ADDR_STAT1: nxt_rdData[7:0] = statByte(flags_ff[1], countUp[1]);
                tmi_pkg::ADDR_STAT2: nxt_rdData[7:0] = statByte(flags_ff[2], countUp[2]);
                tmi_pkg::ADDR_REGA2: nxt_rdData[CNT_W-1:0] = regA2_ff;
                default: nxt_rdData = '0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdData_ff <= '0;
        else
            rdData_ff <= nxt_rdData;
    end

    assign regRdData = rdData_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence sDrive(logic [1:0] code);
        pinMode == tmi_pkg::PIN_DRIVE && ioCtl_ff[1:0] == code && cmpMatch2
            && !(regWrEn && regAddr == tmi_pkg::ADDR_IO_CTL);
    endsequence

    sequence sCap(logic ev, logic [1:0] sel);
        pinMode == tmi_pkg::PIN_CAPTURE && ioCtl_ff[1:0] == sel && ev;
    endsequence

    AST_OC_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        sDrive(tmi_pkg::OC_LOW) |=> !chan2PinAOut && chan2PinAOe)
        else $error("Pin not low after compare match");

    AST_OC_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        sDrive(tmi_pkg::OC_HIGH) |=> chan2PinAOut)
        else $error("Pin not high after compare match");

    AST_OC_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
        sDrive(tmi_pkg::OC_TOGGLE) |=> chan2PinAOut != $past(chan2PinAOut))
        else $error("Pin did not toggle on compare match");

    AST_CAP_RISE: assert property (@(posedge clk) disable iff (!rst_n)
        sCap(riseEv, 2'h0) |=> regA2_ff == $past(cntCh2) && flags_ff[2][tmi_pkg::FLAG_A])
        else $error("Rising edge capture missed");

    AST_CAP_FALL: assert property (@(posedge clk) disable iff (!rst_n)
        sCap(fallEv, 2'h1) |=> regA2_ff == $past(cntCh2))
        else $error("Falling edge capture missed");

    AST_CAP_BOTH: assert property (@(posedge clk) disable iff (!rst_n)
        sCap(riseEv || fallEv, 2'h2) |=> regA2_ff == $past(cntCh2))
        else $error("Both edge capture missed");

    AST_IER_RESET: assert property (@(posedge clk)
        !rst_n |=> ierCh_ff[1] == 8'h00 && irqCh1 == 6'h00)
        else $error("Enable register reset wrong");

    AST_IER_FIXED: assert property (@(posedge clk) disable iff (!rst_n)
        regRdEn && regAddr == tmi_pkg::ADDR_IER2 |=> regRdData[7:6] == 2'h1)
        else $error("Enable bits 7 and 6 read wrong");

    AST_OVF_SET: assert property (@(posedge clk) disable iff (!rst_n)
        wrapUp(prevCnt_ff[1], cntCh1) |=> flags_ff[1][tmi_pkg::FLAG_OV])
        else $error("Overflow flag not set on wrap");

    AST_UDF_CH0: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |-> !flags_ff[0][tmi_pkg::FLAG_UF] && !ierCh_ff[0][tmi_pkg::FLAG_UF])
        else $error("Channel 0 underflow bit not reserved");

    AST_WR_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        regWrEn && regAddr == tmi_pkg::ADDR_STAT1 && regWrData[tmi_pkg::FLAG_OV]
            && flags_ff[1][tmi_pkg::FLAG_OV] |=> flags_ff[1][tmi_pkg::FLAG_OV])
        else $error("Writing one cleared a flag");

    AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!rst_n)
        setEv[1][tmi_pkg::FLAG_OV] && ierCh_ff[1][tmi_pkg::FLAG_OV]
            && !(regWrEn && regAddr == tmi_pkg::ADDR_IER1) |=> irqCh1.overflow)
        else $error("Overflow request not raised");

endmodule

`default_nettype wire

// File: verification/tmi_pin_partner.sv
/*
 * Far-side model: the channel 2 pin wire and an interrupt controller that
 * latches any request it sees.
 * Assumes the block drives the pin only while its output enable is high.
 */
`timescale 1ns/1ps
`default_nettype none

module tmi_pin_partner (
    input wire logic clk,
    input wire logic pinOut,
    input wire logic pinOe,
    input wire logic extLevel,
    output logic pinIn,
    input wire tmi_pkg::tmi_irq_t irqCh0,
    input wire tmi_pkg::tmi_irq_t irqCh1,
    input wire tmi_pkg::tmi_irq_t irqCh2,
    output logic irqSeen
);
    // ------------------------------------------------------------
    // Pin wire
    // ------------------------------------------------------------
    // Outside source only reaches the wire while the block lets go
    assign pinIn = pinOe ? pinOut : extLevel;

    // ------------------------------------------------------------
    // Request latch
    // ------------------------------------------------------------
    // Level requests; a controller never sees one that has no flag
    logic seen = 1'b0;
    always @(posedge clk)
    begin
        seen <= seen | (|irqCh0) | (|irqCh1) | (|irqCh2);
    end
    assign irqSeen = seen;
endmodule

`default_nettype wire

// File: verification/timer_io_and_irq_enable_tb_top.sv
/*
 * Self-checking bench for the pin control and interrupt enable block.
 * Assumes the design map and status clearing of the package.
 */
`timescale 1ns/1ps
`default_nettype none

module timer_io_and_irq_enable_tb_top;
    typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] e;} tmi_row_t;
    typedef struct packed {logic [7:0] io; logic oe; logic lv0; logic lv1;} tmi_oc_t;
    typedef struct packed {logic [7:0] io; logic [15:0] c1; logic [15:0] e1;
        logic [15:0] c2; logic [15:0] e2;} tmi_cap_t;
    // Software keeps enable bits 7 and 6 at zero on every write
    localparam tmi_row_t ROWS [8] = '{'{4'h1, 16'h003F, 16'h005F},
        '{4'h2, 16'h003F, 16'h0073}, '{4'h3, 16'h003F, 16'h0073},
        '{4'h2, 16'h000C, 16'h0040}, '{4'h1, 16'h0000, 16'h0040},
        '{4'h0, 16'h000A, 16'h000A}, '{4'h9, 16'h00FF, 16'h0000},
        '{4'h3, 16'h0000, 16'h0040}};
    localparam tmi_oc_t OC [8] = '{'{8'h01, 1'b1, 1'b0, 1'b0}, '{8'h02, 1'b1, 1'b0, 1'b1},
        '{8'h03, 1'b1, 1'b0, 1'b1}, '{8'h05, 1'b1, 1'b1, 1'b0}, '{8'h06, 1'b1, 1'b1, 1'b1},
        '{8'h07, 1'b1, 1'b1, 1'b0}, '{8'h00, 1'b0, 1'b0, 1'b0}, '{8'h04, 1'b0, 1'b0, 1'b0}};
    localparam tmi_cap_t CAP [4] = '{
        '{8'h08, 16'h1234, 16'h1234, 16'h1111, 16'h1234},
        '{8'h09, 16'h2222, 16'h1234, 16'h3333, 16'h3333},
        '{8'h0A, 16'h4444, 16'h4444, 16'h5555, 16'h5555},
        '{8'h0B, 16'h6666, 16'h6666, 16'h7777, 16'h7777}};

    logic clk, rst_n, regWrEn, regRdEn, chan2PinAIn, chan2PinAOut, chan2PinAOe;
    logic extLevel, irqSeen;
    logic [3:0] regAddr, matchCh0, matchCh1, matchCh2;
    logic [15:0] regWrData, regRdData, cntCh0, cntCh1, cntCh2;
    logic [2:0] phaseMode, countUp;
    tmi_pkg::tmi_irq_t irqCh0, irqCh1, irqCh2;
    int miscompares = 0;
    int testsRun = 0;

    tmi_timer_io_irq dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .cntCh0(cntCh0), .cntCh1(cntCh1), .cntCh2(cntCh2),
        .phaseMode(phaseMode), .countUp(countUp), .matchCh0(matchCh0),
        .matchCh1(matchCh1), .matchCh2(matchCh2), .chan2PinAIn(chan2PinAIn),
        .chan2PinAOut(chan2PinAOut), .chan2PinAOe(chan2PinAOe),
        .irqCh0(irqCh0), .irqCh1(irqCh1), .irqCh2(irqCh2));
    tmi_pin_partner partner (.clk(clk), .pinOut(chan2PinAOut), .pinOe(chan2PinAOe),
        .extLevel(extLevel), .pinIn(chan2PinAIn), .irqCh0(irqCh0), .irqCh1(irqCh1),
        .irqCh2(irqCh2), .irqSeen(irqSeen));

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rdChk(input logic [3:0] a, input logic [15:0] e, input string name);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        check(name, regRdData, e);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run is a few hundred cycles; this is ample margin
    initial
    begin
        #100000;
        miscompares++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        {regAddr, regWrData, regWrEn, regRdEn, matchCh0, matchCh1, matchCh2} = '0;
        {cntCh0, cntCh1, phaseMode, extLevel} = '0;
        cntCh2 = 16'h000F;
        countUp = 3'b111;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ROWS[i])
        begin
            wr(ROWS[i].a, ROWS[i].d);
            rdChk(ROWS[i].a, ROWS[i].e, "register");
        end
        // Second reset in mid-run must restore the enables, status 0 and 2, I/O control and pin enable
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 1; a < 4; a++)
            rdChk(4'(a), 16'h0040, "enable reset");
        rdChk(4'h4, 16'h00C0, "status0 reset");
        rdChk(4'h6, 16'h00C0, "status2 reset");
        rdChk(4'h0, 16'h0000, "io reset");
        check("oe reset", 16'(chan2PinAOe), 16'h0000);
        wr(4'h7, 16'h0010);
        foreach (OC[i])
        begin
            @(posedge clk);
            cntCh2 <= 16'h000F;
            wr(4'h0, {8'h00, OC[i].io});
            tick(2);
            check("pin oe", 16'(chan2PinAOe), 16'(OC[i].oe));
            if (OC[i].oe)
                check("pin init", 16'(chan2PinAOut), 16'(OC[i].lv0));
            @(posedge clk);
            cntCh2 <= 16'h0010;
            tick(3);
            if (OC[i].oe)
                check("pin match", 16'(chan2PinAOut), 16'(OC[i].lv1));
        end
        wr(4'h3, 16'h0001);
        tick(1);
        check("irq2 a", 16'(irqCh2), 16'h0001);
        rdChk(4'h6, 16'h00C1, "status2");
        wr(4'h6, 16'h0000);
        tick(1);
        check("irq2 cleared", 16'(irqCh2), 16'h0000);
        foreach (CAP[i])
        begin
            wr(4'h0, {8'h00, CAP[i].io});
            @(posedge clk);
            cntCh2 <= CAP[i].c1;
            extLevel <= 1'b1;
            tick(3);
            rdChk(4'h7, CAP[i].e1, "capture rise");
            @(posedge clk);
            cntCh2 <= CAP[i].c2;
            extLevel <= 1'b0;
            tick(3);
            rdChk(4'h7, CAP[i].e2, "capture fall");
        end
        wr(4'h2, 16'h0010);
        @(posedge clk);
        cntCh1 <= 16'hFFFF;
        @(posedge clk);
        cntCh1 <= 16'h0000;
        tick(2);
        check("irq1 ov", 16'(irqCh1), 16'h0010);
        @(posedge clk);
        phaseMode <= 3'b010;
        cntCh1 <= 16'hFFFF;
        tick(2);
        check("irq1 uf off", 16'(irqCh1), 16'h0010);
        wr(4'h2, 16'h0030);
        tick(1);
        check("irq1 uf on", 16'(irqCh1), 16'h0030);
        rdChk(4'h5, 16'h00F0, "status1");
        wr(4'h5, 16'h00FF);
        rdChk(4'h5, 16'h00F0, "status1 ones");
        wr(4'h5, 16'h0000);
        rdChk(4'h5, 16'h00C0, "status1 clear");
        check("irq1 clear", 16'(irqCh1), 16'h0000);
        wr(4'h1, 16'h000F);
        @(posedge clk);
        matchCh0 <= 4'hF;
        @(posedge clk);
        matchCh0 <= 4'h0;
        tick(2);
        check("irq0", 16'(irqCh0), 16'h000F);
        wr(4'h1, 16'h0003);
        tick(1);
        check("irq0 masked", 16'(irqCh0), 16'h0003);
        rdChk(4'h4, 16'h00CF, "status0");
        wr(4'h3, 16'h0002);
        @(posedge clk);
        matchCh2 <= 4'h2;
        @(posedge clk);
        matchCh2 <= 4'h0;
        tick(2);
        check("irq2 b", 16'(irqCh2), 16'h0002);
        check("controller saw", 16'(irqSeen), 16'h0001);
        stop_test();
    end
endmodule

`default_nettype wire
